// ---- iccr_regs.sv ----
// apb register bank showing captured alignment-sequence link parameters
// assumes partner logic decodes each lane's parameter octets and pulses cfg_valid
//
// Behaviour
// R1: link page register selects the shown link
// R2: lane 0 parameter octets stored, read-only, reset zero
// R3: bit 7 shows announced scrambling enable
// R4: lane count field holds lanes minus one
// R5: frame octets field holds octets minus one
// R6: multiframe frames field holds count minus one
// R7: version field: 000 earlier, 001 current
// R8: bit 7 shows high density mode
// R9: received checksum readable for lanes 0-3
// R10: computed checksum readable beside received one
// R11: lanes 1-3 identifier in bits 4:0
// R12: lane 0 adds adjust direction, phase adjust
// R13: computed checksum is modulo-256 field sum
// R14: transmitter sends parameters in second multiframe
`timescale 1ns/10ps
module iccr_regs #(
    parameter int NUM_LANES = 4,
    parameter int NUM_LINKS = 2,
    parameter int LINK_W = 1,
    parameter int ADDR_W = 14
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [NUM_LANES-1:0] cfg_valid,
    input wire logic [LINK_W-1:0] cfg_link,
    input wire logic [NUM_LANES*iccr_pkg::CFG_BITS-1:0] cfg_octets,
    output logic [LINK_W-1:0] link_page
);

    // apb phase decode
    logic setup;            // first cycle of a transfer
    logic access;           // second cycle, the one pready closes
    logic [11:0] idx;       // word index, byte address over four
    logic aligned;          // low address bits must be zero

    // registered answer, taken at the setup edge
    logic [31:0] prdata_r;
    logic [31:0] prdata_nxt;
    logic err_r;
    logic err_nxt;
    logic rd_hit;           // address maps to a readable word

    // link page control, the only writable state
    logic [LINK_W-1:0] page_r;

    // per-lane view of the paged link
    logic [NUM_LANES-1:0][iccr_pkg::CFG_BITS-1:0] lane_sel;
    logic [NUM_LANES-1:0][7:0] lane_calc;
    logic [7:0] l0_oct [iccr_pkg::CFG_OCTETS];   // lane 0 octets as an array
    logic [3:0] oct_num;                         // lane 0 octet addressed

    assign setup = psel && !penable;
    assign access = psel && penable;
    assign idx = 12'(paddr[ADDR_W-1:2]);
    assign aligned = (paddr[1:0] == 2'b00);
    assign oct_num = 4'(idx - iccr_pkg::IDX_DEVICE_ID);

    // one capture store per lane; the page picks the link each lane shows
    for (genvar n = 0; n < NUM_LANES; n++) begin : g_lane
        iccr_lane_capture #(
            .NUM_LINKS(NUM_LINKS),
            .LINK_W(LINK_W)
        ) u_cap (
            .pclk(pclk),
            .presetn(presetn),
            .page(page_r),
            .cfg_valid(cfg_valid[n]),
            .cfg_link(cfg_link),
            .cfg_octets(cfg_octets[n*iccr_pkg::CFG_BITS +: iccr_pkg::CFG_BITS]),
            .sel_octets(lane_sel[n]),
            .sel_calc(lane_calc[n])
        );
    end

    // unpack lane 0 so a word index can pick an octet directly
    for (genvar k = 0; k < iccr_pkg::CFG_OCTETS; k++) begin : g_oct
        assign l0_oct[k] = lane_sel[0][k*8 +: 8];
    end

    // read decode; every unmapped or misaligned word answers with an error
    always_comb begin
        prdata_nxt = iccr_pkg::WORD_RESET;
        rd_hit = 1'b0;
        if (idx == iccr_pkg::IDX_LINK_PAGE) begin
            prdata_nxt[LINK_W-1:0] = page_r; // R1
            rd_hit = 1'b1;
        end
        // lane 0 full parameter set, checksum octet included
        if (idx >= iccr_pkg::IDX_DEVICE_ID && idx <= iccr_pkg::IDX_LANE_CHECKSUM[0]) begin
            prdata_nxt[7:0] = l0_oct[oct_num]; // R2 R5 R7
            rd_hit = 1'b1;
        end
        for (int n = 0; n < NUM_LANES; n++) begin
            // lanes beyond 0 show only the identifier, upper bits cleared
            if (n != 0 && idx == iccr_pkg::IDX_LANE_IDENT[n]) begin
                prdata_nxt[7:0] = lane_sel[n][iccr_pkg::OCT_IDENT*8 +: 8]
                    & iccr_pkg::MASK_IDENT_ONLY; // R11
                rd_hit = 1'b1;
            end
            if (idx == iccr_pkg::IDX_LANE_CHECKSUM[n]) begin
                prdata_nxt[7:0] = lane_sel[n][iccr_pkg::OCT_CHECKSUM*8 +: 8]; // R9
                rd_hit = 1'b1;
            end
            if (idx == iccr_pkg::IDX_LANE_CALC[n]) begin
                prdata_nxt[7:0] = lane_calc[n]; // R10
                rd_hit = 1'b1;
            end
        end
        if (!aligned) begin
            prdata_nxt = iccr_pkg::WORD_RESET;
            rd_hit = 1'b0;
        end
    end

    // error: reads need a mapped word, writes only land on the page register
    always_comb begin
        if (pwrite) begin
            err_nxt = !(aligned && idx == iccr_pkg::IDX_LINK_PAGE);
        end else begin
            err_nxt = !rd_hit;
        end
    end

    // answer latched at setup, so prdata is a flop and no wait state is added
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= iccr_pkg::WORD_RESET;
            err_r <= 1'b0;
        end else if (setup) begin
            // writes return zero data; the value is not meaningful for them
            prdata_r <= pwrite ? iccr_pkg::WORD_RESET : prdata_nxt;
            err_r <= err_nxt;
        end
    end

    // page register; a write without byte lane 0 leaves it unchanged
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            page_r <= '0;
        end else if (access && pwrite && !err_r && pstrb[0]) begin
            page_r <= pwdata[LINK_W-1:0]; // R1
        end
    end

    // handshake outputs are combinational over the access cycle
    assign pready = access;
    assign pslverr = access && err_r;
    assign prdata = prdata_r;
    assign link_page = page_r;

    // the captured fields assume the partner delivers the second multiframe octets
    // through cfg_valid and cfg_octets, one pulse per lane per sequence (R14)

    // ---------------- checks ----------------
    sequence s_rd(logic [11:0] i);
        setup && !pwrite && aligned && idx == i;
    endsequence

    a_ready_access: assert property (@(posedge pclk) disable iff (!presetn)
        setup |=> pready) else $error("access phase without ready");

    a_page_write: assert property (@(posedge pclk) disable iff (!presetn) // R1
        (access && pwrite && !pslverr && pstrb[0] && idx == iccr_pkg::IDX_LINK_PAGE)
            |=> link_page == $past(pwdata[LINK_W-1:0]))
        else $error("page write not taken");

    a_page_readback: assert property (@(posedge pclk) disable iff (!presetn) // R1
        s_rd(iccr_pkg::IDX_LINK_PAGE) |=> pready && !pslverr
            && prdata == {{(32 - LINK_W){1'b0}}, $past(page_r)})
        else $error("page readback wrong");

    a_device_id: assert property (@(posedge pclk) disable iff (!presetn) // R2
        s_rd(iccr_pkg::IDX_DEVICE_ID) |=> !pslverr
            && prdata == {24'h000000, $past(lane_sel[0][7:0])})
        else $error("device id read wrong");

    a_ro_write_err: assert property (@(posedge pclk) disable iff (!presetn) // R2
        (setup && pwrite && idx == iccr_pkg::IDX_BANK_ID) |=> pslverr && $stable(page_r))
        else $error("write to read-only word not refused");

    a_scramble_bit: assert property (@(posedge pclk) disable iff (!presetn) // R3
        s_rd(iccr_pkg::IDX_SCRAMBLE_LANES) |=> prdata[iccr_pkg::SCR_BIT]
            == $past(lane_sel[0][iccr_pkg::OCT_SCR_L*8 + iccr_pkg::SCR_BIT]))
        else $error("scrambling bit wrong");

    a_lane_count: assert property (@(posedge pclk) disable iff (!presetn) // R4
        s_rd(iccr_pkg::IDX_SCRAMBLE_LANES) |=> prdata[6:5] == 2'b00
            && prdata[4:0] == $past(lane_sel[0][iccr_pkg::OCT_SCR_L*8 +: 5]))
        else $error("lane count field wrong");

    a_frame_octets: assert property (@(posedge pclk) disable iff (!presetn) // R5
        s_rd(iccr_pkg::IDX_FRAME_OCTETS) |=> prdata[31:8] == 24'h000000
            && prdata[7:0] == $past(lane_sel[0][iccr_pkg::OCT_FRAME*8 +: 8]))
        else $error("frame octets field wrong");

    a_mf_frames: assert property (@(posedge pclk) disable iff (!presetn) // R6
        s_rd(iccr_pkg::IDX_MF_FRAMES) |=> prdata[7:5] == 3'b000
            && prdata[4:0] == $past(lane_sel[0][iccr_pkg::OCT_MF*8 +: 5]))
        else $error("multiframe field wrong");

    a_version_field: assert property (@(posedge pclk) disable iff (!presetn) // R7
        s_rd(iccr_pkg::IDX_VERSION_SAMPLES) |=> prdata[7:5]
            == $past(lane_sel[0][iccr_pkg::OCT_VER_S*8 + 5 +: 3]))
        else $error("version field wrong");

    a_density_bit: assert property (@(posedge pclk) disable iff (!presetn) // R8
        s_rd(iccr_pkg::IDX_DENSITY_WORDS) |=> prdata[6:5] == 2'b00
            && prdata[iccr_pkg::HD_BIT]
            == $past(lane_sel[0][iccr_pkg::OCT_HD_CF*8 + iccr_pkg::HD_BIT]))
        else $error("density bit wrong");

    a_rx_checksum: assert property (@(posedge pclk) disable iff (!presetn) // R9
        s_rd(iccr_pkg::IDX_LANE_CHECKSUM[NUM_LANES-1]) |=> !pslverr
            && prdata[7:0]
            == $past(lane_sel[NUM_LANES-1][iccr_pkg::OCT_CHECKSUM*8 +: 8]))
        else $error("received checksum wrong");

    a_calc_checksum: assert property (@(posedge pclk) disable iff (!presetn) // R10
        s_rd(iccr_pkg::IDX_LANE_CALC[0]) |=> prdata[7:0] == $past(lane_calc[0]))
        else $error("computed checksum read wrong");

    a_ident_upper: assert property (@(posedge pclk) disable iff (!presetn) // R11
        s_rd(iccr_pkg::IDX_LANE_IDENT[NUM_LANES-1]) |=> prdata[7:5] == 3'b000
            && prdata[4:0]
            == $past(lane_sel[NUM_LANES-1][iccr_pkg::OCT_IDENT*8 +: 5]))
        else $error("lane identifier read wrong");

    a_lane0_adjust: assert property (@(posedge pclk) disable iff (!presetn) // R12
        s_rd(iccr_pkg::IDX_LANE_IDENT[0]) |=> prdata[7] == 1'b0
            && prdata[6:5]
            == $past(lane_sel[0][iccr_pkg::OCT_IDENT*8 + iccr_pkg::PHADJ_BIT +: 2]))
        else $error("lane 0 adjust flags wrong");

    a_capture_paged: assert property (@(posedge pclk) disable iff (!presetn) // R1
        (cfg_valid[0] && cfg_link == page_r) ##1 $stable(page_r)
            |-> lane_sel[0][7:0] == $past(cfg_octets[7:0]))
        else $error("capture on shown page not visible");

    c_page_write: cover property (@(posedge pclk) disable iff (!presetn)
        access && pwrite && !pslverr);
    c_capture_read: cover property (@(posedge pclk) disable iff (!presetn)
        cfg_valid[0] ##[1:20] s_rd(iccr_pkg::IDX_LANE_CALC[0]));
    c_error_answer: cover property (@(posedge pclk) disable iff (!presetn)
        pslverr);

endmodule

// ---- iccr_pkg.sv ----
// constants for the alignment-sequence capture register bank
// assumes 32-bit apb words; printed offsets are word indices, byte address = 4 * index
package iccr_pkg;

    // parameter octets carried in the second multiframe of the alignment sequence
    localparam int CFG_OCTETS = 14;
    localparam int CFG_BITS = CFG_OCTETS * 8;
    localparam int MAX_LANES = 4;

    // word indices of the bank
    localparam logic [11:0] IDX_LINK_PAGE = 12'h300;
    localparam logic [11:0] IDX_DEVICE_ID = 12'h400;
    localparam logic [11:0] IDX_BANK_ID = 12'h401;
    localparam logic [11:0] IDX_SCRAMBLE_LANES = 12'h403;
    localparam logic [11:0] IDX_FRAME_OCTETS = 12'h404;
    localparam logic [11:0] IDX_MF_FRAMES = 12'h405;
    localparam logic [11:0] IDX_CONVERTERS = 12'h406;
    localparam logic [11:0] IDX_CTRL_RES = 12'h407;
    localparam logic [11:0] IDX_SUBCLASS_BITS = 12'h408;
    localparam logic [11:0] IDX_VERSION_SAMPLES = 12'h409;
    localparam logic [11:0] IDX_DENSITY_WORDS = 12'h40a;
    localparam logic [11:0] IDX_SPARE_ONE = 12'h40b;
    localparam logic [11:0] IDX_SPARE_TWO = 12'h40c;
    // per-lane identifier, received checksum and computed checksum, lanes 3..0
    localparam logic [MAX_LANES-1:0][11:0] IDX_LANE_IDENT =
        {12'h422, 12'h41a, 12'h412, 12'h402};
    localparam logic [MAX_LANES-1:0][11:0] IDX_LANE_CHECKSUM =
        {12'h425, 12'h41d, 12'h415, 12'h40d};
    localparam logic [MAX_LANES-1:0][11:0] IDX_LANE_CALC =
        {12'h426, 12'h41e, 12'h416, 12'h40e};

    // octet numbers inside the captured parameter set
    localparam int OCT_DEVICE_ID = 0;
    localparam int OCT_BANK_ID = 1;
    localparam int OCT_IDENT = 2;
    localparam int OCT_SCR_L = 3;
    localparam int OCT_FRAME = 4;
    localparam int OCT_MF = 5;
    localparam int OCT_CONV = 6;
    localparam int OCT_CS_N = 7;
    localparam int OCT_SUB_NP = 8;
    localparam int OCT_VER_S = 9;
    localparam int OCT_HD_CF = 10;
    localparam int OCT_CHECKSUM = 13;

    // field positions
    localparam int FLD5_MSB = 4;      // 5-bit fields sit in [4:0]
    localparam int FLD3_LSB = 5;      // 3-bit upper fields sit in [7:5]
    localparam int CS_LSB = 6;        // control bits sit in [7:6]
    localparam int NIB_LSB = 4;       // upper nibble of the bank octet
    localparam int SCR_BIT = 7;
    localparam int HD_BIT = 7;
    localparam int ADJDIR_BIT = 6;
    localparam int PHADJ_BIT = 5;

    // masks clearing reserved bits so they read as zero
    localparam logic [7:0] MASK_IDENT = 8'h7f;
    localparam logic [7:0] MASK_IDENT_ONLY = 8'h1f;
    localparam logic [7:0] MASK_SCR_L = 8'h9f;
    localparam logic [7:0] MASK_MF = 8'h1f;
    localparam logic [7:0] MASK_CS_N = 8'hdf;
    localparam logic [7:0] MASK_HD_CF = 8'h9f;

    // reset values
    localparam logic [7:0] OCTET_RESET = 8'h00;
    localparam logic [31:0] WORD_RESET = 32'h0000_0000;

endpackage

// ---- iccr_lane_capture.sv ----
// one lane's capture store: a parameter set and computed checksum per link
// assumes cfg_valid pulses for one cycle with cfg_octets holding the decoded octets
`timescale 1ns/10ps
module iccr_lane_capture #(
    parameter int NUM_LINKS = 2,
    parameter int LINK_W = 1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [LINK_W-1:0] page,
    input wire logic cfg_valid,
    input wire logic [LINK_W-1:0] cfg_link,
    input wire logic [iccr_pkg::CFG_BITS-1:0] cfg_octets,
    output logic [iccr_pkg::CFG_BITS-1:0] sel_octets,
    output logic [7:0] sel_calc
);

    // field-wise modulo-256 sum over the received parameters, reserved octets excluded
    function automatic logic [7:0] field_sum(input logic [iccr_pkg::CFG_BITS-1:0] o);
        logic [7:0] s;
        logic [7:0] b [iccr_pkg::CFG_OCTETS];
        for (int k = 0; k < iccr_pkg::CFG_OCTETS; k++) begin
            b[k] = o[k*8 +: 8];
        end
        s = b[iccr_pkg::OCT_DEVICE_ID];
        s = s + {4'h0, b[iccr_pkg::OCT_BANK_ID][iccr_pkg::NIB_LSB-1:0]};
        s = s + {4'h0, b[iccr_pkg::OCT_BANK_ID][7:iccr_pkg::NIB_LSB]};
        s = s + {3'h0, b[iccr_pkg::OCT_IDENT][iccr_pkg::FLD5_MSB:0]};
        s = s + {7'h00, b[iccr_pkg::OCT_IDENT][iccr_pkg::PHADJ_BIT]};
        s = s + {7'h00, b[iccr_pkg::OCT_IDENT][iccr_pkg::ADJDIR_BIT]};
        s = s + {3'h0, b[iccr_pkg::OCT_SCR_L][iccr_pkg::FLD5_MSB:0]};
        s = s + {7'h00, b[iccr_pkg::OCT_SCR_L][iccr_pkg::SCR_BIT]};
        s = s + b[iccr_pkg::OCT_FRAME];
        s = s + {3'h0, b[iccr_pkg::OCT_MF][iccr_pkg::FLD5_MSB:0]};
        s = s + b[iccr_pkg::OCT_CONV];
        s = s + {3'h0, b[iccr_pkg::OCT_CS_N][iccr_pkg::FLD5_MSB:0]};
        s = s + {6'h00, b[iccr_pkg::OCT_CS_N][7:iccr_pkg::CS_LSB]};
        s = s + {3'h0, b[iccr_pkg::OCT_SUB_NP][iccr_pkg::FLD5_MSB:0]};
        s = s + {5'h00, b[iccr_pkg::OCT_SUB_NP][7:iccr_pkg::FLD3_LSB]};
        s = s + {3'h0, b[iccr_pkg::OCT_VER_S][iccr_pkg::FLD5_MSB:0]};
        s = s + {5'h00, b[iccr_pkg::OCT_VER_S][7:iccr_pkg::FLD3_LSB]};
        s = s + {3'h0, b[iccr_pkg::OCT_HD_CF][iccr_pkg::FLD5_MSB:0]};
        s = s + {7'h00, b[iccr_pkg::OCT_HD_CF][iccr_pkg::HD_BIT]};
        return s;
    endfunction

    // reserved bits inside the field octets are dropped on the way in so reads show them as zero
    function automatic logic [iccr_pkg::CFG_BITS-1:0] strip(
        input logic [iccr_pkg::CFG_BITS-1:0] o);
        logic [iccr_pkg::CFG_BITS-1:0] r;
        r = o;
        r[iccr_pkg::OCT_IDENT*8 +: 8] = o[iccr_pkg::OCT_IDENT*8 +: 8] & iccr_pkg::MASK_IDENT; // R12
        r[iccr_pkg::OCT_SCR_L*8 +: 8] = o[iccr_pkg::OCT_SCR_L*8 +: 8] & iccr_pkg::MASK_SCR_L; // R3 R4
        r[iccr_pkg::OCT_MF*8 +: 8] = o[iccr_pkg::OCT_MF*8 +: 8] & iccr_pkg::MASK_MF; // R6
        r[iccr_pkg::OCT_CS_N*8 +: 8] = o[iccr_pkg::OCT_CS_N*8 +: 8] & iccr_pkg::MASK_CS_N;
        r[iccr_pkg::OCT_HD_CF*8 +: 8] = o[iccr_pkg::OCT_HD_CF*8 +: 8] & iccr_pkg::MASK_HD_CF; // R8
        return r;
    endfunction

    logic [iccr_pkg::CFG_BITS-1:0] store_r [NUM_LINKS];   // one parameter set per link
    logic [7:0] calc_r [NUM_LINKS];                       // checksum computed per link

    // capture: only the addressed link's copy changes, so other pages stay intact
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int j = 0; j < NUM_LINKS; j++) begin
                store_r[j] <= '0;
                calc_r[j] <= iccr_pkg::OCTET_RESET;
            end
        end else if (cfg_valid && (int'(cfg_link) < NUM_LINKS)) begin
            store_r[cfg_link] <= strip(cfg_octets);
            // summed from the raw octets, so a received checksum can be compared
            calc_r[cfg_link] <= field_sum(cfg_octets); // R13
        end
    end

    // page selects which link is shown
    always_comb begin
        sel_octets = store_r[0];
        sel_calc = calc_r[0];
        if (int'(page) < NUM_LINKS) begin
            sel_octets = store_r[page]; // R1
            sel_calc = calc_r[page]; // R10
        end
    end

    property p_calc_sum;
        @(posedge pclk) disable iff (!presetn)
        (cfg_valid && cfg_link == page && $stable(page)) ##1 $stable(page)
            |-> sel_calc == field_sum($past(cfg_octets));
    endproperty
    a_calc_field_sum: assert property (p_calc_sum) else $error("computed checksum wrong"); // R13

endmodule

// ---- iccr_tx_model.sv ----
// partner model: transmitter side delivering decoded alignment-sequence octets
// assumes a single pclk domain; the bench calls send() from its main sequence
`timescale 1ns/10ps
module iccr_tx_model (
    input wire logic pclk,
    output logic [3:0] cfg_valid,
    output logic [0:0] cfg_link,
    output logic [4*iccr_pkg::CFG_BITS-1:0] cfg_octets
);
    // idle at time zero, octet bus holds a pattern rather than zeros
    initial begin
        cfg_valid = 4'h0;
        cfg_link = 1'b0;
        cfg_octets = {56{8'ha5}};
    end

    // one parameter set per lane, sent once per second multiframe
    task automatic send(input logic [3:0] lanes, input logic lk, input logic [447:0] oct);
        @(posedge pclk);
        cfg_valid <= lanes;
        cfg_link <= lk;
        cfg_octets <= oct;
        @(posedge pclk);
        cfg_valid <= 4'h0;
        // octets are not held after the pulse, so show the inverse
        cfg_octets <= ~oct;
        cfg_link <= ~lk;
    endtask
endmodule

// ---- test_ilas_config_capture_regs.sv ----
// self-checking bench for the capture register bank, apb master plus model
// assumes the partner model in iccr_tx_model and the bank's default parameters
`timescale 1ns/10ps
module test_ilas_config_capture_regs;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [13:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb, cfg_valid;
    logic [0:0] cfg_link, link_page;
    logic [447:0] cfg_octets, oc;
    logic [7:0] mem [2][4][14]; // model store per link, lane, octet
    logic [11:0] idxq[$]; // mapped word indices
    int n_errors, checked, cyc, lk;
    logic [3:0] lanes;

    iccr_regs #(.NUM_LANES(4), .NUM_LINKS(2), .LINK_W(1), .ADDR_W(14)) i_iccr_regs (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cfg_valid(cfg_valid), .cfg_link(cfg_link),
        .cfg_octets(cfg_octets), .link_page(link_page));
    iccr_tx_model i_iccr_tx_model (.pclk(pclk), .cfg_valid(cfg_valid), .cfg_link(cfg_link),
        .cfg_octets(cfg_octets));

    // 25 mhz clock
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    // hang guard, far above the roughly 1300 cycles the run needs
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        if (n_errors == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask

    // one apb transfer; waits for pready, never assumes a latency
    task automatic apb(input logic w, input logic [13:0] a, input logic [31:0] d,
        input logic [3:0] s, output logic [31:0] rd, output logic er);
        int t;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        t = 0;
        do begin
            @(posedge pclk);
            t++;
        end while (pready !== 1'b1 && t < 16);
        if (pready !== 1'b1) begin
            n_errors++;
            report_and_stop();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // modulo-256 sum of the received fields of one lane
    function automatic logic [7:0] csum(int k, int n);
        logic [7:0] m [14];
        m = mem[k][n];
        return m[0] + m[1][3:0] + m[1][7:4] + m[2][4:0] + m[2][5] + m[2][6] + m[3][4:0]
            + m[3][7] + m[4] + m[5][4:0] + m[6] + m[7][4:0] + m[7][7:6] + m[8][4:0]
            + m[8][7:5] + m[9][4:0] + m[9][7:5] + m[10][4:0] + m[10][7];
    endfunction

    // expected word at a mapped index; reserved bits read zero
    function automatic logic [31:0] expw(int k, logic [11:0] ix);
        logic [7:0] msk [13] = '{8'hff, 8'hff, 8'h7f, 8'h9f, 8'hff, 8'h1f, 8'hff,
            8'hdf, 8'hff, 8'hff, 8'h9f, 8'hff, 8'hff};
        int n;
        if (ix <= 12'h40c) begin
            return 32'(mem[k][0][ix - 12'h400] & msk[ix - 12'h400]);
        end
        n = (int'(ix) - 32'h40a) >> 3;
        case (ix[2:0])
            3'd2: return 32'(mem[k][n][2] & 8'h1f);
            3'd5: return 32'(mem[k][n][13]);
            default: return 32'(csum(k, n));
        endcase
    endfunction

    // select each page, then read every mapped word and compare with the model
    task automatic sweep();
        logic [31:0] rd;
        logic er;
        for (int p = 0; p < 2; p++) begin
            apb(1'b1, 14'hc00, 32'(p), 4'hf, rd, er);
            chk(32'(er), 32'h0, "page write error");
            apb(1'b0, 14'hc00, $urandom, 4'($urandom), rd, er);
            chk(rd, 32'(p), "page read");
            chk(32'(link_page), 32'(p), "page port");
            foreach (idxq[i]) begin
                apb(1'b0, {idxq[i], 2'b00}, $urandom, 4'($urandom), rd, er);
                chk(rd, expw(p, idxq[i]), "register read");
                chk(32'(er), 32'h0, "read error");
            end
        end
    endtask

    initial begin
        logic [31:0] rd;
        logic er;
        {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
        presetn = 1'b0;
        mem = '{default: 8'h00};
        n_errors = 0;
        checked = 0;
        cyc = 0;
        for (int k = 0; k < 15; k++) idxq.push_back(12'h400 + 12'(k));
        for (int n = 1; n < 4; n++) begin
            idxq.push_back(12'h40a + 12'(8 * n));
            idxq.push_back(12'h40d + 12'(8 * n));
            idxq.push_back(12'h40e + 12'(8 * n));
        end
        void'($urandom(32'hc639ffee));
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        sweep();
        // refused accesses: read-only write, unmapped, misaligned; then a strobe-less page write, answered without error
        apb(1'b1, 14'h1004, 32'hff, 4'hf, rd, er);
        chk(32'(er), 32'h1, "write to read-only");
        chk(32'(link_page), 32'h1, "page after refused write");
        apb(1'b0, 14'h1040, 32'h0, 4'hf, rd, er);
        chk({rd[30:0], er}, 32'h1, "unmapped read");
        apb(1'b0, 14'h1001, 32'h0, 4'hf, rd, er);
        chk(32'(er), 32'h1, "misaligned read");
        // the sweep leaves page 1 selected; a strobe-less write of 0 must not move it
        apb(1'b1, 14'hc00, 32'h0, 4'h0, rd, er);
        chk(32'(er), 32'h0, "strobe-less page write error");
        apb(1'b0, 14'hc00, 32'h0, 4'hf, rd, er);
        chk(rd, 32'h1, "page kept");
        // captures on both links, lane 0 fields steered through both encodings
        for (int r = 0; r < 6; r++) begin
            lk = $urandom_range(0, 1);
            lanes = (r == 0) ? 4'hf : 4'($urandom_range(1, 15));
            for (int w = 0; w < 14; w++) oc[w * 32 +: 32] = $urandom;
            oc[31] = r[0];
            oc[28:24] = r[0] ? 5'd3 : 5'd0;
            oc[39:32] = r[0] ? 8'h03 : 8'h00;
            oc[44:40] = r[0] ? oc[44:40] : 5'd0;
            oc[79:77] = {2'b00, r[0]};
            oc[87] = ~r[0];
            i_iccr_tx_model.send(lanes, lk[0], oc);
            for (int n = 0; n < 4; n++) begin
                for (int k = 0; k < 14; k++) begin
                    if (lanes[n]) mem[lk][n][k] = oc[n * 112 + k * 8 +: 8];
                end
            end
            sweep();
        end
        // second reset in mid-run clears everything
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        mem = '{default: 8'h00};
        sweep();
        report_and_stop();
    end
endmodule
